//--- hdl/eik_edge_det.sv
// one interrupt source: unregistered level pass-through and active edge detect
`timescale 1ns/10ps
module eik_edge_det (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic active_in,
  output logic      level_o,
  output logic      edge_o
);
  logic prev_r;
  logic prev_nxt;

  always_comb begin
    prev_nxt = active_in;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_r <= 1'b1;
    end else begin
      prev_r <= prev_nxt;
    end
  end

  // prev resets high so a source already active at reset is not an edge
  assign level_o = active_in;
  assign edge_o  = active_in & ~prev_r;
endmodule : eik_edge_det

//--- hdl/eik_pkg.sv
// package: register map, field positions and reset values of the external interrupt block
package eik_pkg;
  localparam int          ADDR_W          = 5;
  localparam logic [4:0]  OFF_PORT_A_DATA = 5'h00;
  localparam logic [4:0]  OFF_PORT_A_DIR  = 5'h04;
  localparam logic [4:0]  OFF_ISC         = 5'h0d;
  localparam logic [4:0]  OFF_PULLDOWN    = 5'h10;
  localparam int          BIT_ENABLE      = 7;
  localparam int          BIT_PENDING     = 3;
  localparam int          BIT_ACK         = 1;
  localparam int          PORT_A_W        = 6;
  localparam int          KEY_W           = 4;
  localparam int          PORT_C_W        = 8;
  localparam int          BIT_PDC_LO      = 6;
  localparam int          BIT_PDC_HI      = 7;
  localparam logic [7:0]  RST_DATA        = 8'h00;
  localparam logic [7:0]  RST_DIR         = 8'h00;
  localparam logic [7:0]  RST_PULLDOWN    = 8'h00;
  localparam logic        RST_ENABLE      = 1'b1;
endpackage : eik_pkg

//--- hdl/eik_top.sv
// external interrupt pin, keypad-capable port a and its pulldowns
//
// Summary of operation
// RULE1: the active-low interrupt pin raises requests on its falling edge, plus low level if the level option is set.
// RULE2: in level mode the board pulls the pin up so open-drain sources can share it.
// RULE3: an unused interrupt pin is tied high by the board.
// RULE4: with the port a option the four low port a lines are ORed into the single request.
// RULE5: the ORed port a lines are active on rising edges and high levels.
// RULE6: the port a lines use the same edge or edge-plus-level setting as the pin.
// RULE7: port a has six bidirectional lines, four of them keyboard interrupt capable.
// RULE8: every port pin has a software pulldown, removed entirely by the inhibit option.
// RULE9: all registers lie in the first 32 bytes and are reached as ordinary memory.
// RULE10: the interrupt status and control register sits at 0x0d.
// RULE11: port a data sits at 0x00 and port a direction at 0x04.
// RULE12: the port a and port c pulldown register sits at 0x10, port c bits only on the large package.
// RULE13: the status and control register holds enable, pending flag and write-only acknowledge.
// RULE14: an active edge latches pending until acknowledged; level mode re-asserts while a source is active.
`timescale 1ns/10ps
module eik_top #(
  parameter bit LEVEL_SENSE     = 1'b0,
  parameter bit PORT_A_IRQ      = 1'b0,
  parameter bit PULLDOWN_INHIBIT = 1'b0,
  parameter bit HAS_PORT_C      = 1'b0
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [4:0]  cpu_addr,
  input  wire logic        cpu_wr,
  input  wire logic        cpu_rd,
  input  wire logic [7:0]  cpu_wdata,
  output logic      [7:0]  cpu_rdata,
  input  wire logic        irq_n_pin,
  input  wire logic [5:0]  port_a_in,
  output logic      [5:0]  port_a_out,
  output logic      [5:0]  port_a_oe,
  output logic      [5:0]  port_a_pulldown_en,
  output logic      [1:0]  port_c_pulldown_en,
  output logic             ext_irq_req
);
  localparam int NSRC = eik_pkg::KEY_W + 1;

  logic [5:0] data_r, data_nxt;
  logic [5:0] dir_r, dir_nxt;
  logic [7:0] pd_r, pd_nxt;
  logic       en_r, en_nxt;
  logic       pend_r, pend_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic       req_r, req_nxt;
  logic [5:0] pa_pd_r, pa_pd_nxt;
  logic [1:0] pc_pd_r, pc_pd_nxt;

  logic [NSRC-1:0] src_act;
  logic [NSRC-1:0] src_lvl;
  logic [NSRC-1:0] src_edge;
  logic            any_edge;
  logic            any_lvl;
  logic            wr_isc;
  logic            wr_data;
  logic            wr_dir;
  logic            wr_pd;
  logic            ack;

  // source 0 is the pin, inverted to active high
  always_comb begin
    src_act[0] = ~irq_n_pin; // RULE1
    for (int i = 1; i < NSRC; i++) begin
      src_act[i] = PORT_A_IRQ & port_a_in[i-1]; // RULE4 RULE5 RULE7
    end
  end

  // pin is treated as synchronous, with no synchronizer; edge sampled each clock
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_src
      eik_edge_det u_det (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .active_in (src_act[g]),
        .level_o   (src_lvl[g]),
        .edge_o    (src_edge[g])
      );
    end
  endgenerate

  assign any_edge = |src_edge; // RULE4
  assign any_lvl  = LEVEL_SENSE & (|src_lvl); // RULE1 RULE6
  assign wr_isc   = cpu_wr && (cpu_addr == eik_pkg::OFF_ISC); // RULE10
  assign ack      = wr_isc && cpu_wdata[eik_pkg::BIT_ACK]; // RULE13

  // write strobes per register; unmapped addresses hit none of them
  assign wr_data = cpu_wr && (cpu_addr == eik_pkg::OFF_PORT_A_DATA); // RULE11
  assign wr_dir  = cpu_wr && (cpu_addr == eik_pkg::OFF_PORT_A_DIR); // RULE11
  assign wr_pd   = cpu_wr && (cpu_addr == eik_pkg::OFF_PULLDOWN); // RULE12

  // port a latch and direction
  always_comb begin
    data_nxt = data_r;
    dir_nxt  = dir_r;
    if (wr_data) begin
      data_nxt = cpu_wdata[5:0]; // RULE11
    end
    if (wr_dir) begin
      dir_nxt = cpu_wdata[5:0]; // RULE11
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_r <= eik_pkg::RST_DATA[5:0];
      dir_r  <= eik_pkg::RST_DIR[5:0];
    end else begin
      data_r <= data_nxt;
      dir_r  <= dir_nxt;
    end
  end

  // pulldown register, write-only from the bus side
  always_comb begin
    pd_nxt = pd_r;
    if (wr_pd) begin
      pd_nxt = cpu_wdata; // RULE12
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pd_r <= eik_pkg::RST_PULLDOWN;
    end else begin
      pd_r <= pd_nxt;
    end
  end

  // port a pulldown only on lines set as inputs, so an output never fights it; port c pulldowns are not gated by direction
  always_comb begin
    pa_pd_nxt = pd_nxt[5:0] & ~dir_nxt; // RULE8
    pc_pd_nxt = 2'h0;
    if (HAS_PORT_C) begin
      pc_pd_nxt = pd_nxt[eik_pkg::BIT_PDC_HI:eik_pkg::BIT_PDC_LO]; // RULE12
    end
    // inhibit option removes every pulldown, whatever software writes
    if (PULLDOWN_INHIBIT) begin
      pa_pd_nxt = 6'h00; // RULE8
      pc_pd_nxt = 2'h0; // RULE8
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pa_pd_r <= 6'h00;
      pc_pd_r <= 2'h0;
    end else begin
      pa_pd_r <= pa_pd_nxt;
      pc_pd_r <= pc_pd_nxt;
    end
  end

  // enable, pending flag and the registered request
  always_comb begin
    en_nxt   = en_r;
    pend_nxt = pend_r;
    if (wr_isc) begin
      en_nxt = cpu_wdata[eik_pkg::BIT_ENABLE]; // RULE13
    end
    // set wins over acknowledge; level keeps pending while held
    if (ack) begin
      pend_nxt = 1'b0; // RULE13
    end
    if (any_edge || any_lvl) begin
      pend_nxt = 1'b1; // RULE14
    end
    // pending sets even while disabled; only the request is gated
    req_nxt = en_nxt & pend_nxt; // RULE14
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      en_r   <= eik_pkg::RST_ENABLE;
      pend_r <= 1'b0;
      req_r  <= 1'b0;
    end else begin
      en_r   <= en_nxt;
      pend_r <= pend_nxt;
      req_r  <= req_nxt;
    end
  end

  // read data stands for one cycle and is zero otherwise
  always_comb begin
    rdata_nxt = 8'h00;
    if (cpu_rd) begin
      case (cpu_addr) // RULE9
        eik_pkg::OFF_PORT_A_DATA: begin
          // output lines read the latch, inputs read the pin
          rdata_nxt = {2'b00, (dir_r & data_r) | (~dir_r & port_a_in)}; // RULE11
        end
        eik_pkg::OFF_PORT_A_DIR: begin
          rdata_nxt = {2'b00, dir_r}; // RULE11
        end
        eik_pkg::OFF_ISC: begin
          rdata_nxt[eik_pkg::BIT_ENABLE]  = en_r; // RULE13
          rdata_nxt[eik_pkg::BIT_PENDING] = pend_r; // RULE13
        end
        // pulldown register is write-only; acknowledge bit reads as zero
        default: begin
          rdata_nxt = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign cpu_rdata          = rdata_r;
  assign port_a_out         = data_r;
  assign port_a_oe          = dir_r; // RULE7
  assign port_a_pulldown_en = pa_pd_r;
  assign port_c_pulldown_en = pc_pd_r;
  assign ext_irq_req        = req_r; // RULE14
endmodule : eik_top

//--- verification/eik_keypad.sv
// keypad switches and wired-or interrupt sources outside the block
`timescale 1ns/10ps
module eik_keypad (
  input  wire logic       pull,
  input  wire logic [3:0] keys,
  input  wire logic [5:0] pa_out,
  input  wire logic [5:0] pa_oe,
  output logic            irq_n,
  output logic      [5:0] pa_in
);
  assign irq_n = pull ? 1'b0 : 1'b1;
  // undriven lines settle at the pulldown level
  assign pa_in = (pa_out & pa_oe) | ({2'b00, keys} & ~pa_oe);
endmodule : eik_keypad

//--- verification/eik_top_properties.sv
// concurrent checks on the external interrupt block ports
`timescale 1ns/10ps
module eik_props #(
  parameter bit LEVEL_SENSE = 1'b0
) (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic [4:0] cpu_addr,
  input wire logic       cpu_wr,
  input wire logic       cpu_rd,
  input wire logic [7:0] cpu_wdata,
  input wire logic [7:0] cpu_rdata,
  input wire logic       irq_n_pin,
  input wire logic [5:0] port_a_in,
  input wire logic [5:0] port_a_oe,
  input wire logic [5:0] port_a_pulldown_en,
  input wire logic       ext_irq_req
);
  logic en_r;
  logic en_nxt;
  logic isc_wr;
  assign isc_wr = cpu_wr && cpu_addr == 5'h0d;
  always_comb en_nxt = isc_wr ? cpu_wdata[7] : en_r;
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst) en_r <= 1'b1;
    else en_r <= en_nxt;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_pin_fall: assert property ($fell(irq_n_pin) && en_r && !isc_wr |=> ext_irq_req)
    else $error("pin fall lost");
  a_key_rise: assert property (
    |(port_a_in[3:0] & ~$past(port_a_in[3:0])) && en_r && !isc_wr |=> ext_irq_req)
    else $error("key rise lost");
  a_req_holds: assert property (ext_irq_req && !isc_wr |=> ext_irq_req)
    else $error("request dropped");
  a_ack_clears: assert property (
    isc_wr && cpu_wdata[1] && $stable(irq_n_pin) && $stable(port_a_in)
    && !(LEVEL_SENSE && (!irq_n_pin || (|port_a_in[3:0])))
    |-> ##[1:2] !ext_irq_req)
    else $error("ack ignored");
  a_lvl_holds: assert property (
    LEVEL_SENSE && (!irq_n_pin || (|port_a_in[3:0])) && en_r && !isc_wr |=> ext_irq_req)
    else $error("level request lost");
  a_rd_idle: assert property (!cpu_rd |=> cpu_rdata == 8'h00)
    else $error("rdata not idle");
  a_isc_fields: assert property (
    cpu_rd && cpu_addr == 5'h0d |=> cpu_rdata[6:4] == 3'h0 && cpu_rdata[2:0] == 3'h0)
    else $error("status fields");
  a_no_readback: assert property (
    cpu_rd && (cpu_addr == 5'h10 || cpu_addr == 5'h07) |=> cpu_rdata == 8'h00)
    else $error("readback seen");
  a_pd_input: assert property ((port_a_pulldown_en & port_a_oe) == 6'h00)
    else $error("pulldown on output");
  a_dir_write: assert property (
    cpu_wr && cpu_addr == 5'h04 |=> port_a_oe == $past(cpu_wdata[5:0]))
    else $error("direction write");
endmodule : eik_props
bind eik_top eik_props #(.LEVEL_SENSE(LEVEL_SENSE)) u_props (.*);

//--- verification/eik_top_test.sv
// register-level bench for the external interrupt block
`timescale 1ns/10ps
module eik_top_test;
  logic       clk = 1'b0, sys_rst = 1'b1, wr = 1'b0, rd = 1'b0, pull = 1'b0, irq_n, req;
  logic [4:0] a = 5'h00;
  logic [7:0] wd = 8'h00, rdata;
  logic [3:0] keys = 4'h0;
  logic [5:0] pa_in, pa_out, pa_oe, pd;
  logic [1:0] pdc;
  logic       req_l;
  logic [7:0] rdata_l;
  logic [5:0] pd_l;
  logic [1:0] pdc_l;
  int         mismatches = 0, n_tests = 0;
  always #12.5 clk = ~clk;
  eik_top #(.PORT_A_IRQ(1'b1), .HAS_PORT_C(1'b1)) dut (.clk(clk), .sys_rst(sys_rst),
    .cpu_addr(a), .cpu_wr(wr), .cpu_rd(rd), .cpu_wdata(wd), .cpu_rdata(rdata),
    .irq_n_pin(irq_n), .port_a_in(pa_in), .port_a_out(pa_out), .port_a_oe(pa_oe),
    .port_a_pulldown_en(pd), .port_c_pulldown_en(pdc), .ext_irq_req(req));
  eik_keypad u_pad (.pull(pull), .keys(keys), .pa_out(pa_out), .pa_oe(pa_oe),
    .irq_n(irq_n), .pa_in(pa_in));
  // level-sensitive build with pulldowns inhibited, same bus and pins
  eik_top #(.LEVEL_SENSE(1'b1), .PORT_A_IRQ(1'b1), .PULLDOWN_INHIBIT(1'b1), .HAS_PORT_C(1'b1))
    dut_lvl (.clk(clk), .sys_rst(sys_rst), .cpu_addr(a), .cpu_wr(wr), .cpu_rd(rd),
    .cpu_wdata(wd), .cpu_rdata(rdata_l), .irq_n_pin(irq_n), .port_a_in(pa_in),
    .port_a_out(), .port_a_oe(), .port_a_pulldown_en(pd_l), .port_c_pulldown_en(pdc_l),
    .ext_irq_req(req_l));
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : step
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [4:0] ad, input logic [7:0] d);
    a = ad;
    wd = d;
    wr = 1'b1;
    step(1);
    wr = 1'b0;
    step(1);
  endtask : wr_reg
  task automatic rd_reg(input logic [4:0] ad, input logic [7:0] exp);
    a = ad;
    rd = 1'b1;
    step(1);
    rd = 1'b0;
    chk(rdata, exp);
    chk(rdata_l, exp);
    step(1);
  endtask : rd_reg
  task automatic end_of_test;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  initial begin
    step(4);
    sys_rst = 1'b0;
    rd_reg(5'h0d, 8'h80);
    wr_reg(5'h04, 8'h30);
    wr_reg(5'h00, 8'h3f);
    chk({2'b00, pa_out}, 8'h3f);
    chk({2'b00, pa_oe}, 8'h30);
    rd_reg(5'h04, 8'h30);
    rd_reg(5'h00, 8'h30);
    wr_reg(5'h10, 8'hff);
    chk({2'b00, pd}, 8'h0f);
    chk({6'h00, pdc}, 8'h03);
    chk({2'b00, pd_l}, 8'h00);
    chk({6'h00, pdc_l}, 8'h00);
    rd_reg(5'h10, 8'h00);
    rd_reg(5'h07, 8'h00);
    pull = 1'b1;
    step(2);
    chk({7'h00, req}, 8'h01);
    chk({7'h00, req_l}, 8'h01);
    pull = 1'b0;
    step(2);
    rd_reg(5'h0d, 8'h88);
    wr_reg(5'h0d, 8'h82);
    step(1);
    chk({7'h00, req}, 8'h00);
    chk({7'h00, req_l}, 8'h00);
    keys = 4'h4;
    step(2);
    chk({7'h00, req}, 8'h01);
    wr_reg(5'h0d, 8'h82);
    step(1);
    chk({7'h00, req}, 8'h00);
    chk({7'h00, req_l}, 8'h01);
    keys = 4'h0;
    wr_reg(5'h0d, 8'h00);
    keys = 4'h1;
    step(2);
    chk({7'h00, req}, 8'h00);
    chk({7'h00, req_l}, 8'h00);
    rd_reg(5'h00, 8'h31);
    wr_reg(5'h0d, 8'h80);
    step(1);
    chk({7'h00, req}, 8'h01);
    chk({7'h00, req_l}, 8'h01);
    end_of_test();
  end
endmodule : eik_top_test
